// [rtl/usrcfg_pkg.sv]
package usrcfg_pkg;
   // special-function register addresses
   localparam logic [7:0] ADDR_DATA = 8'hC1;
   localparam logic [7:0] ADDR_MANT = 8'hC2;
   localparam logic [7:0] ADDR_UCR = 8'hC4;
   localparam logic [7:0] ADDR_GCR = 8'hC5;
   // async frame control fields
   localparam int UCR_FLUSH = 7;
   localparam int UCR_RSVD = 6;
   localparam int UCR_D9 = 5;
   localparam int UCR_NINE_BIT_FRAME_ENABLE = 4;
   localparam int UCR_PAR = 3;
   localparam int UCR_SPB = 2;
   localparam int UCR_STOP = 1;
   localparam int UCR_START = 0;
   // generic control fields
   localparam int GCR_SCK_IDLE_POLARITY = 7;
   localparam int GCR_CPHA = 6;
   localparam int GCR_ORDER = 5;
   localparam int GCR_EXP_HI = 4;
   localparam int GCR_EXP_LO = 0;
   // reset values
   localparam logic [7:0] UCR_RST = 8'h02;
   localparam logic [7:0] GCR_RST = 8'h00;
   localparam logic [7:0] MANT_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   // rate generator: (256 + m) * 2^e / 2^28 per clock
   localparam logic [8:0] RATE_BASE = 9'h100;
   localparam int ACC_W = 28;
   localparam int STEP_W = 40;
   localparam logic [ACC_W-1:0] ACC_HALF = 28'h8000000;
   localparam logic [ACC_W-1:0] ACC_ZERO = 28'h0000000;
   // transfer sizes
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [4:0] LAST_SPI_EDGE = 5'h0F;
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} usrcfg_uart_t;
   typedef enum logic {SPI_IDLE, SPI_RUN} usrcfg_spi_t;
endpackage

// [rtl/usrcfg_top.sv]
`timescale 1ns/1ps
module usrcfg_top (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WE,
   input wire logic SFR_RE,
   output logic [7:0] SFR_RDATA,
   input wire logic MODE_UART,
   input wire logic SPI_SLAVE,
   input wire logic RX_ENABLE,
   output logic UART_TXD,
   input wire logic UART_RXD,
   output logic SPI_SCK_OUT,
   output logic SPI_SCK_OE,
   input wire logic SPI_SCK_IN,
   output logic SPI_MOSI_OUT,
   output logic SPI_MOSI_OE,
   input wire logic SPI_MOSI_IN,
   output logic SPI_MISO_OUT,
   output logic SPI_MISO_OE,
   input wire logic SPI_MISO_IN,
   input wire logic SPI_SSN_N,
   output logic BUSY,
   output logic TX_DONE,
   output logic RX_DONE,
   output logic RX_FRAME_ERR,
   output logic RX_PARITY_ERR
);
   localparam int AW = usrcfg_pkg::ACC_W;
   localparam int SW = usrcfg_pkg::STEP_W;

   function automatic logic [SW:0] rate_step(input logic [AW-1:0] acc, input logic [7:0] m,
                                              input logic [4:0] e);
      logic [SW-1:0] inc;
      inc = {31'h0, usrcfg_pkg::RATE_BASE + {1'b0, m}} << e;
      rate_step = {{(SW+1-AW){1'b0}}, acc} + {1'b0, inc};
   endfunction

   function automatic logic out_bit(input logic [7:0] sh, input logic msb);
      out_bit = msb ? sh[7] : sh[0];
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic msb);
      shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
   endfunction

   // register file
   logic [6:0] ucr_q, ucr_d;
   logic [7:0] gcr_q, gcr_d, mant_q, mant_d;
   logic [7:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d, rdata_q, rdata_d;
   logic pend_q, pend_d;
   logic flush;
   // engine handshakes into the register file
   logic tx_take, rx_load;
   logic [7:0] rx_byte;

   always_comb
   begin
      ucr_d = ucr_q;
      gcr_d = gcr_q;
      mant_d = mant_q;
      txbuf_d = txbuf_q;
      rxbuf_d = rxbuf_q;
      pend_d = pend_q;
      rdata_d = rdata_q;
      flush = 1'b0;
      if (tx_take)
         pend_d = 1'b0;
      if (rx_load)
         rxbuf_d = rx_byte;
      if (SFR_WE)
      begin
         unique case (SFR_ADDR)
            usrcfg_pkg::ADDR_DATA:
            begin
               txbuf_d = SFR_WDATA;
               pend_d = 1'b1;
            end
            usrcfg_pkg::ADDR_MANT: mant_d = SFR_WDATA;
            usrcfg_pkg::ADDR_UCR:
            begin
               ucr_d = SFR_WDATA[usrcfg_pkg::UCR_RSVD:0];
               flush = SFR_WDATA[usrcfg_pkg::UCR_FLUSH];
            end
            usrcfg_pkg::ADDR_GCR: gcr_d = SFR_WDATA;
            default: ;
         endcase
      end
      if (flush)
      begin
         txbuf_d = usrcfg_pkg::DATA_RST;
         rxbuf_d = usrcfg_pkg::DATA_RST;
         pend_d = 1'b0;
      end
      if (SFR_RE)
      begin
         unique case (SFR_ADDR)
            usrcfg_pkg::ADDR_DATA: rdata_d = rxbuf_q;
            usrcfg_pkg::ADDR_MANT: rdata_d = mant_q;
            usrcfg_pkg::ADDR_UCR: rdata_d = {1'b0, ucr_q};
            usrcfg_pkg::ADDR_GCR: rdata_d = gcr_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         ucr_q <= usrcfg_pkg::UCR_RST[usrcfg_pkg::UCR_RSVD:0];
         gcr_q <= usrcfg_pkg::GCR_RST;
         mant_q <= usrcfg_pkg::MANT_RST;
         txbuf_q <= usrcfg_pkg::DATA_RST;
         rxbuf_q <= usrcfg_pkg::DATA_RST;
         pend_q <= 1'b0;
         rdata_q <= 8'h00;
      end
      else if (CE)
      begin
         ucr_q <= ucr_d;
         gcr_q <= gcr_d;
         mant_q <= mant_d;
         txbuf_q <= txbuf_d;
         rxbuf_q <= rxbuf_d;
         pend_q <= pend_d;
         rdata_q <= rdata_d;
      end
   end

   // field views
   logic d9, nine, par, two_stop, stop_lvl, start_lvl, sck_idle_polarity, cpha, msb;
   logic [4:0] rexp;
   assign d9 = ucr_q[usrcfg_pkg::UCR_D9];
   assign nine = ucr_q[usrcfg_pkg::UCR_NINE_BIT_FRAME_ENABLE];
   assign par = ucr_q[usrcfg_pkg::UCR_PAR];
   assign two_stop = ucr_q[usrcfg_pkg::UCR_SPB];
   assign stop_lvl = ucr_q[usrcfg_pkg::UCR_STOP];
   assign start_lvl = ucr_q[usrcfg_pkg::UCR_START];
   assign sck_idle_polarity = gcr_q[usrcfg_pkg::GCR_SCK_IDLE_POLARITY];
   assign cpha = gcr_q[usrcfg_pkg::GCR_CPHA];
   assign msb = gcr_q[usrcfg_pkg::GCR_ORDER];
   assign rexp = gcr_q[usrcfg_pkg::GCR_EXP_HI:usrcfg_pkg::GCR_EXP_LO];

   // engines: uart transmit, uart receive, spi; one rate phase per direction
   usrcfg_pkg::usrcfg_uart_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
   usrcfg_pkg::usrcfg_spi_t sp_st_q, sp_st_d;
   logic [AW-1:0] tacc_q, tacc_d, racc_q, racc_d;
   logic [3:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
   logic [4:0] sp_cnt_q, sp_cnt_d;
   logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, sp_sh_q, sp_sh_d;
   logic tx_nin_q, tx_nin_d, rx_nin_q, rx_nin_d;
   logic txd_q, txd_d, sck_q, sck_d, dout_q, dout_d, sck_prev_q;
   logic txdone_q, txdone_d, rxdone_q, rxdone_d, ferr_q, ferr_d, perr_q, perr_d;
   logic [SW:0] tsum, rsum;
   logic tick, half, rtick, edge_ev, lead, sample, drive, din;
   logic master;

   always_comb
   begin
      tsum = rate_step(tacc_q, mant_q, rexp);
      rsum = rate_step(racc_q, mant_q, rexp);
      // several crossings in one cycle collapse into one event
      tick = |tsum[SW:AW];
      half = tsum[SW:AW-1] != {{(SW+1-AW){1'b0}}, tacc_q[AW-1]};
      rtick = |rsum[SW:AW];
      master = !SPI_SLAVE;
      tacc_d = tsum[AW-1:0];
      racc_d = rsum[AW-1:0];
      tx_st_d = tx_st_q;
      rx_st_d = rx_st_q;
      sp_st_d = sp_st_q;
      tx_cnt_d = tx_cnt_q;
      rx_cnt_d = rx_cnt_q;
      sp_cnt_d = sp_cnt_q;
      tx_sh_d = tx_sh_q;
      rx_sh_d = rx_sh_q;
      sp_sh_d = sp_sh_q;
      tx_nin_d = tx_nin_q;
      rx_nin_d = rx_nin_q;
      txd_d = txd_q;
      sck_d = sck_q;
      dout_d = dout_q;
      txdone_d = 1'b0;
      rxdone_d = 1'b0;
      ferr_d = 1'b0;
      perr_d = 1'b0;
      tx_take = 1'b0;
      rx_load = 1'b0;
      rx_byte = rx_sh_q;
      // slave edges come from the pin, master edges from the half-bit tick
      edge_ev = master ? (sp_st_q == usrcfg_pkg::SPI_RUN && half)
                       : (!SPI_SSN_N && SPI_SCK_IN != sck_prev_q);
      lead = master ? !sp_cnt_q[0] : (sck_prev_q == sck_idle_polarity);
      sample = edge_ev && (cpha ? !lead : lead);
      drive = edge_ev && (cpha ? lead : !lead);
      din = master ? SPI_MISO_IN : SPI_MOSI_IN;
      if (MODE_UART)
      begin
         unique case (tx_st_q)
            usrcfg_pkg::ST_IDLE:
            begin
               txd_d = !start_lvl;
               if (pend_q)
               begin
                  tx_take = 1'b1;
                  tx_sh_d = txbuf_q;
                  tx_nin_d = par ? (^txbuf_q) ^ d9 : d9;
                  tacc_d = usrcfg_pkg::ACC_ZERO;
                  txd_d = start_lvl;
                  tx_st_d = usrcfg_pkg::ST_START;
               end
            end
            usrcfg_pkg::ST_START:
               if (tick)
               begin
                  tx_cnt_d = 4'h0;
                  txd_d = out_bit(tx_sh_q, msb);
                  tx_st_d = usrcfg_pkg::ST_DATA;
               end
            usrcfg_pkg::ST_DATA:
               if (tick)
               begin
                  tx_sh_d = msb ? {tx_sh_q[6:0], 1'b0} : {1'b0, tx_sh_q[7:1]};
                  tx_cnt_d = tx_cnt_q + 4'h1;
                  txd_d = out_bit(tx_sh_d, msb);
                  if (tx_cnt_q == usrcfg_pkg::LAST_DATA_BIT)
                  begin
                     tx_cnt_d = 4'h0;
                     tx_st_d = nine ? usrcfg_pkg::ST_NINTH : usrcfg_pkg::ST_STOP;
                     txd_d = nine ? tx_nin_q : stop_lvl;
                  end
               end
            usrcfg_pkg::ST_NINTH:
               if (tick)
               begin
                  txd_d = stop_lvl;
                  tx_st_d = usrcfg_pkg::ST_STOP;
               end
            usrcfg_pkg::ST_STOP:
               if (tick)
               begin
                  if (two_stop && tx_cnt_q == 4'h0)
                     tx_cnt_d = 4'h1;
                  else
                  begin
                     txd_d = !start_lvl;
                     txdone_d = 1'b1;
                     tx_st_d = usrcfg_pkg::ST_IDLE;
                  end
               end
            default: tx_st_d = usrcfg_pkg::ST_IDLE;
         endcase
         unique case (rx_st_q)
            usrcfg_pkg::ST_IDLE:
               if (RX_ENABLE && UART_RXD == start_lvl)
               begin
                  // mid-bit sampling: the phase starts half a bit in
                  racc_d = usrcfg_pkg::ACC_HALF;
                  rx_st_d = usrcfg_pkg::ST_START;
               end
            usrcfg_pkg::ST_START:
               if (rtick)
               begin
                  rx_cnt_d = 4'h0;
                  // a start shorter than half a bit is a glitch
                  rx_st_d = (UART_RXD == start_lvl) ? usrcfg_pkg::ST_DATA
                                                    : usrcfg_pkg::ST_IDLE;
               end
            usrcfg_pkg::ST_DATA:
               if (rtick)
               begin
                  rx_sh_d = shift_in(rx_sh_q, UART_RXD, msb);
                  rx_cnt_d = rx_cnt_q + 4'h1;
                  if (rx_cnt_q == usrcfg_pkg::LAST_DATA_BIT)
                     rx_st_d = nine ? usrcfg_pkg::ST_NINTH : usrcfg_pkg::ST_STOP;
               end
            usrcfg_pkg::ST_NINTH:
               if (rtick)
               begin
                  rx_nin_d = UART_RXD;
                  rx_st_d = usrcfg_pkg::ST_STOP;
               end
            usrcfg_pkg::ST_STOP:
               if (rtick)
               begin
                  // only the first stop bit is checked on receive
                  ferr_d = UART_RXD != stop_lvl;
                  perr_d = nine && par && (rx_nin_q != ((^rx_sh_q) ^ d9));
                  rx_load = 1'b1;
                  rxdone_d = 1'b1;
                  rx_st_d = usrcfg_pkg::ST_IDLE;
               end
            default: rx_st_d = usrcfg_pkg::ST_IDLE;
         endcase
      end
      else
      begin
         unique case (sp_st_q)
            usrcfg_pkg::SPI_IDLE:
            begin
               sck_d = sck_idle_polarity;
               sp_cnt_d = 5'h00;
               if ((master && pend_q) || (!master && !SPI_SSN_N))
               begin
                  tx_take = pend_q;
                  sp_sh_d = pend_q ? txbuf_q : usrcfg_pkg::DATA_RST;
                  dout_d = out_bit(sp_sh_d, msb);
                  tacc_d = usrcfg_pkg::ACC_ZERO;
                  sp_st_d = usrcfg_pkg::SPI_RUN;
               end
            end
            usrcfg_pkg::SPI_RUN:
            begin
               if (edge_ev)
               begin
                  sp_cnt_d = sp_cnt_q + 5'h01;
                  sck_d = !sck_q;
               end
               if (sample)
                  sp_sh_d = shift_in(sp_sh_q, din, msb);
               if (drive)
                  dout_d = out_bit(sp_sh_q, msb);
               if (edge_ev && sp_cnt_q == usrcfg_pkg::LAST_SPI_EDGE)
               begin
                  rx_load = 1'b1;
                  rx_byte = sp_sh_d;
                  rxdone_d = 1'b1;
                  txdone_d = 1'b1;
                  sp_st_d = usrcfg_pkg::SPI_IDLE;
               end
               if (!master && SPI_SSN_N)
                  sp_st_d = usrcfg_pkg::SPI_IDLE;
            end
            default: sp_st_d = usrcfg_pkg::SPI_IDLE;
         endcase
      end
      if (flush)
      begin
         tx_st_d = usrcfg_pkg::ST_IDLE;
         rx_st_d = usrcfg_pkg::ST_IDLE;
         sp_st_d = usrcfg_pkg::SPI_IDLE;
         tx_sh_d = usrcfg_pkg::DATA_RST;
         rx_sh_d = usrcfg_pkg::DATA_RST;
         sp_sh_d = usrcfg_pkg::DATA_RST;
         txd_d = !start_lvl;
         sck_d = sck_idle_polarity;
         tx_take = 1'b0;
         rx_load = 1'b0;
         txdone_d = 1'b0;
         rxdone_d = 1'b0;
         ferr_d = 1'b0;
         perr_d = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         tx_st_q <= usrcfg_pkg::ST_IDLE;
         rx_st_q <= usrcfg_pkg::ST_IDLE;
         sp_st_q <= usrcfg_pkg::SPI_IDLE;
         tacc_q <= usrcfg_pkg::ACC_ZERO;
         racc_q <= usrcfg_pkg::ACC_ZERO;
         tx_cnt_q <= 4'h0;
         rx_cnt_q <= 4'h0;
         sp_cnt_q <= 5'h00;
         tx_sh_q <= 8'h00;
         rx_sh_q <= 8'h00;
         sp_sh_q <= 8'h00;
         tx_nin_q <= 1'b0;
         rx_nin_q <= 1'b0;
         txd_q <= !usrcfg_pkg::UCR_RST[usrcfg_pkg::UCR_START];
         sck_q <= usrcfg_pkg::GCR_RST[usrcfg_pkg::GCR_SCK_IDLE_POLARITY];
         dout_q <= 1'b0;
         sck_prev_q <= 1'b0;
         txdone_q <= 1'b0;
         rxdone_q <= 1'b0;
         ferr_q <= 1'b0;
         perr_q <= 1'b0;
      end
      else if (CE)
      begin
         tx_st_q <= tx_st_d;
         rx_st_q <= rx_st_d;
         sp_st_q <= sp_st_d;
         tacc_q <= tacc_d;
         racc_q <= racc_d;
         tx_cnt_q <= tx_cnt_d;
         rx_cnt_q <= rx_cnt_d;
         sp_cnt_q <= sp_cnt_d;
         tx_sh_q <= tx_sh_d;
         rx_sh_q <= rx_sh_d;
         sp_sh_q <= sp_sh_d;
         tx_nin_q <= tx_nin_d;
         rx_nin_q <= rx_nin_d;
         txd_q <= txd_d;
         sck_q <= sck_d;
         dout_q <= dout_d;
         sck_prev_q <= SPI_SCK_IN;
         txdone_q <= txdone_d;
         rxdone_q <= rxdone_d;
         ferr_q <= ferr_d;
         perr_q <= perr_d;
      end
   end

   assign SFR_RDATA = rdata_q;
   assign UART_TXD = txd_q;
   assign SPI_SCK_OUT = sck_q;
   assign SPI_SCK_OE = !MODE_UART && !SPI_SLAVE;
   assign SPI_MOSI_OUT = dout_q;
   assign SPI_MOSI_OE = !MODE_UART && !SPI_SLAVE;
   assign SPI_MISO_OUT = dout_q;
   assign SPI_MISO_OE = !MODE_UART && SPI_SLAVE && !SPI_SSN_N;
   assign BUSY = tx_st_q != usrcfg_pkg::ST_IDLE || rx_st_q != usrcfg_pkg::ST_IDLE
                 || sp_st_q != usrcfg_pkg::SPI_IDLE;
   assign TX_DONE = txdone_q;
   assign RX_DONE = rxdone_q;
   assign RX_FRAME_ERR = ferr_q;
   assign RX_PARITY_ERR = perr_q;
endmodule

// [test/usrcfg_chk_asserts.sv]
`timescale 1ns/1ps
module usrcfg_chk (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WE,
   input wire logic SFR_RE,
   input wire logic [7:0] SFR_RDATA,
   input wire logic MODE_UART,
   input wire logic SPI_SLAVE,
   input wire logic UART_TXD,
   input wire logic SPI_SCK_OUT,
   input wire logic SPI_SCK_OE,
   input wire logic BUSY,
   input wire logic TX_DONE,
   input wire logic RX_DONE
);
   logic [7:0] ucr_q, ucr_d, gcr_q, gcr_d, mnt_q, mnt_d;
   logic wr, rd;
   assign wr = CE && SFR_WE;
   assign rd = CE && SFR_RE && !SFR_WE;
   // shadow copies; the abort bit never lands in storage
   always_comb
   begin
      ucr_d = (wr && SFR_ADDR == usrcfg_pkg::ADDR_UCR) ? (SFR_WDATA & 8'h7F) : ucr_q;
      gcr_d = (wr && SFR_ADDR == usrcfg_pkg::ADDR_GCR) ? SFR_WDATA : gcr_q;
      mnt_d = (wr && SFR_ADDR == usrcfg_pkg::ADDR_MANT) ? SFR_WDATA : mnt_q;
   end
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         ucr_q <= usrcfg_pkg::UCR_RST;
         gcr_q <= usrcfg_pkg::GCR_RST;
         mnt_q <= usrcfg_pkg::MANT_RST;
      end
      else
      begin
         ucr_q <= ucr_d;
         gcr_q <= gcr_d;
         mnt_q <= mnt_d;
      end
   end
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);
   chk_ucr_readback: assert property (rd && SFR_ADDR == usrcfg_pkg::ADDR_UCR
      |=> SFR_RDATA == $past(ucr_q)) else $error("async control readback wrong");
   chk_gcr_readback: assert property (rd && SFR_ADDR == usrcfg_pkg::ADDR_GCR
      |=> SFR_RDATA == $past(gcr_q)) else $error("generic control readback wrong");
   chk_mant_readback: assert property (rd && SFR_ADDR == usrcfg_pkg::ADDR_MANT
      |=> SFR_RDATA == $past(mnt_q)) else $error("mantissa readback wrong");
   chk_flush_to_idle: assert property (wr && SFR_ADDR == usrcfg_pkg::ADDR_UCR && SFR_WDATA[7]
      |=> !BUSY && !TX_DONE && !RX_DONE) else $error("abort did not idle the unit");
   chk_txd_idle_level: assert property (MODE_UART && !BUSY && $past(!BUSY) && $stable(ucr_q)
      |-> UART_TXD == !ucr_q[0]) else $error("idle line not opposite of start");
   chk_sck_idle_level: assert property (!MODE_UART && !SPI_SLAVE && !BUSY && $past(!BUSY)
      && $stable(gcr_q) |-> SPI_SCK_OUT == gcr_q[7]) else $error("sck idle level wrong");
   chk_sck_drive_mode: assert property (SPI_SCK_OE == (!MODE_UART && !SPI_SLAVE))
      else $error("sck enable does not follow mode");
   chk_tx_start_level: assert property (wr && SFR_ADDR == usrcfg_pkg::ADDR_DATA && MODE_UART
      && !BUSY |-> ##[2:3] (UART_TXD == ucr_q[0] && BUSY)) else $error("start bit missing");
   chk_stop_bit_level: assert property (MODE_UART && TX_DONE
      |-> $past(UART_TXD, 3) == ucr_q[1]) else $error("stop bit level wrong");
endmodule
bind usrcfg_top usrcfg_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .CE(CE),
   .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE),
   .SFR_RDATA(SFR_RDATA), .MODE_UART(MODE_UART), .SPI_SLAVE(SPI_SLAVE), .UART_TXD(UART_TXD),
   .SPI_SCK_OUT(SPI_SCK_OUT), .SPI_SCK_OE(SPI_SCK_OE), .BUSY(BUSY), .TX_DONE(TX_DONE),
   .RX_DONE(RX_DONE));

// [test/usrcfg_peer.sv]
`timescale 1ns/1ps
module usrcfg_peer #(parameter int P = 16) (
   input wire logic clk,
   input wire logic [7:0] ucr,
   input wire logic [7:0] gcr,
   input wire logic txd,
   output logic rxd,
   input wire logic sck,
   input wire logic mosi,
   output logic miso
);
   logic [10:0] q[$];
   logic [7:0] b, rb;
   logic [7:0] stx = 8'h00;
   logic act = 1'b0;
   logic drv, lst, n9, s1, s2, ps;
   int di = 0;
   int k;
   assign rxd = act ? drv : !ucr[0];
   assign k = di - gcr[6];
   // outside a byte the line shows the inverse of its last bit
   assign miso = (k >= 0 && k < 8) ? stx[gcr[5] ? 7 - k : k] : !stx[gcr[5] ? 0 : 7];
   always
   begin
      @(posedge clk);
      if (txd === ucr[0] && lst === !ucr[0])
      begin
         repeat (P / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (P) @(posedge clk);
            b[i] = txd;
         end
         if (gcr[5])
            b = {<<{b}};
         n9 = 1'b0;
         if (ucr[4])
         begin
            repeat (P) @(posedge clk);
            n9 = txd;
         end
         repeat (P) @(posedge clk);
         s1 = txd;
         s2 = s1;
         if (ucr[2])
         begin
            repeat (P) @(posedge clk);
            s2 = txd;
         end
         q.push_back({s2, s1, n9, b});
      end
      lst = txd;
   end
   task automatic send(input logic [7:0] d, input logic p9, input logic sv);
      drv <= ucr[0];
      act <= 1'b1;
      repeat (P) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         drv <= d[gcr[5] ? 7 - i : i];
         repeat (P) @(posedge clk);
      end
      if (ucr[4])
      begin
         drv <= p9;
         repeat (P) @(posedge clk);
      end
      drv <= sv;
      // short stop so a bad stop level cannot pose as a new start
      repeat (P / 2 + 3) @(posedge clk);
      act <= 1'b0;
      repeat (P) @(posedge clk);
   endtask
   task automatic arm(input logic [7:0] t);
      stx <= t;
      di <= 0;
   endtask
   always @(posedge clk)
   begin
      ps <= sck;
      if (sck !== ps)
      begin
         if ((ps === gcr[7]) ^ gcr[6])
            rb <= gcr[5] ? {rb[6:0], mosi} : {mosi, rb[7:1]};
         else
            di <= di + 1;
      end
   end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
   localparam int P = 16;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic we = 1'b0;
   logic re = 1'b0;
   logic mode = 1'b1;
   logic slave = 1'b0;
   logic rxen = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] ucr = 8'h02;
   logic [7:0] gcr = 8'h10;
   logic ce = 1'b1;
   logic ssn = 1'b1;
   logic sck_in = 1'b0;
   logic smosi = 1'b0;
   logic miso_o, miso_oe;
   logic [7:0] rdat, v, d, s;
   logic txd, rxd, sck, sck_oe, mosi, mosi_oe, miso, busy, txdn, rxdn, fe, pe;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   always #50 clk = ~clk;
   usrcfg_top dut (.REF_CLK(clk), .RESET(rst), .CE(ce), .SFR_ADDR(addr), .SFR_WDATA(wd),
      .SFR_WE(we), .SFR_RE(re), .SFR_RDATA(rdat), .MODE_UART(mode), .SPI_SLAVE(slave),
      .RX_ENABLE(rxen), .UART_TXD(txd), .UART_RXD(rxd), .SPI_SCK_OUT(sck), .SPI_SCK_OE(sck_oe),
      .SPI_SCK_IN(sck_in), .SPI_MOSI_OUT(mosi), .SPI_MOSI_OE(mosi_oe), .SPI_MOSI_IN(smosi),
      .SPI_MISO_OUT(miso_o), .SPI_MISO_OE(miso_oe), .SPI_MISO_IN(miso), .SPI_SSN_N(ssn),
      .BUSY(busy),
      .TX_DONE(txdn), .RX_DONE(rxdn), .RX_FRAME_ERR(fe), .RX_PARITY_ERR(pe));
   // undriven clock and data wires float high
   usrcfg_peer #(.P(P)) peer (.clk(clk), .ucr(ucr), .gcr(gcr), .txd(txd), .rxd(rxd),
      .sck(sck_oe ? sck : 1'b1), .mosi(mosi_oe ? mosi : 1'b1), .miso(miso));
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      addr = a;
      wd = x;
      we = 1'b1;
      @(posedge clk);
      #1 we = 1'b0;
      // idle cycle so a following call never re-raises the strobe in the same step
      wt(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] x);
      addr = a;
      re = 1'b1;
      @(posedge clk);
      #1 re = 1'b0;
      x = rdat;
      wt(1);
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic done(input logic rx, output int c);
      c = 0;
      while ((rx ? rxdn : txdn) !== 1'b1 && c < 3000)
      begin
         wt(1);
         c++;
      end
      chk(c < 3000, 1'b1);
   endtask
   task end_of_test;
      if (n_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         end_of_test;
      end
   end
   initial
   begin
      void'($urandom(32'h5EAC4BCB));
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      foreach (s[i])
      begin
         rd(8'hC0 + 8'(i), v);
         chk(v, (i == 4) ? 8'h02 : 8'h00);
      end
      for (int i = 0; i < 4; i++)
      begin
         d = $urandom;
         wr(usrcfg_pkg::ADDR_MANT, d);
         rd(usrcfg_pkg::ADDR_MANT, v);
         chk(v, d);
         gcr = $urandom;
         wr(usrcfg_pkg::ADDR_GCR, gcr);
         rd(usrcfg_pkg::ADDR_GCR, v);
         chk(v, gcr);
         ucr = 8'($urandom) & 8'h3F;
         wr(usrcfg_pkg::ADDR_UCR, ucr);
         rd(usrcfg_pkg::ADDR_UCR, v);
         chk(v, ucr);
      end
      wr(usrcfg_pkg::ADDR_MANT, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         gcr = {2'h0, 1'($urandom), 5'h10};
         ucr = {2'h0, i[2:0], 3'($urandom)};
         wr(usrcfg_pkg::ADDR_GCR, gcr);
         wr(usrcfg_pkg::ADDR_UCR, ucr);
         d = $urandom;
         wt(2);
         wr(usrcfg_pkg::ADDR_DATA, d);
         done(1'b0, n);
         chk(n / P, 10 + ucr[4] + ucr[2]);
         wt(2);
         chk(peer.q.size(), 1);
         chk(peer.q.pop_front(), {{2{ucr[1]}}, ucr[4] & (ucr[3] ? ^d ^ ucr[5] : ucr[5]), d});
      end
      gcr = 8'h10;
      ucr = {2'h0, 1'($urandom), 5'h1A};
      wr(usrcfg_pkg::ADDR_GCR, gcr);
      wr(usrcfg_pkg::ADDR_UCR, ucr);
      rxen = 1'b1;
      for (int j = 0; j < 3; j++)
      begin
         d = $urandom;
         fork
            peer.send(d, ^d ^ ucr[5] ^ (j == 1), j != 2);
         join_none
         done(1'b1, n);
         chk({fe, pe}, {j == 2, j == 1});
         wait fork;
         rd(usrcfg_pkg::ADDR_DATA, v);
         chk(v, d);
      end
      wr(usrcfg_pkg::ADDR_DATA, 8'hA5);
      wt(40);
      wr(usrcfg_pkg::ADDR_UCR, ucr | 8'h80);
      chk({busy, txd}, {1'b0, !ucr[0]});
      n = 0;
      repeat (300)
      begin
         wt(1);
         n += txdn;
      end
      chk(n, 0);
      rd(usrcfg_pkg::ADDR_DATA, v);
      chk(v, 8'h00);
      rd(usrcfg_pkg::ADDR_UCR, v);
      chk(v, ucr);
      ce = 1'b0;
      wr(usrcfg_pkg::ADDR_MANT, 8'h5A);
      ce = 1'b1;
      rd(usrcfg_pkg::ADDR_MANT, v);
      chk(v, 8'h00);
      peer.q.delete();
      mode = 1'b0;
      rxen = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         gcr = {i[2:0], 5'h11};
         wr(usrcfg_pkg::ADDR_GCR, gcr);
         wt(2);
         d = $urandom;
         s = $urandom;
         peer.arm(s);
         wr(usrcfg_pkg::ADDR_DATA, d);
         done(1'b0, n);
         chk(n / 8, 8);
         wt(2);
         chk(peer.rb, d);
         rd(usrcfg_pkg::ADDR_DATA, v);
         chk(v, s);
      end
      slave = 1'b1;
      gcr = 8'h11;
      wr(usrcfg_pkg::ADDR_GCR, gcr);
      d = $urandom;
      s = $urandom;
      wr(usrcfg_pkg::ADDR_DATA, d);
      ssn = 1'b0;
      wt(2);
      chk(miso_oe, 1'b1);
      for (int i = 0; i < 8; i++)
      begin
         smosi = s[i];
         wt(4);
         sck_in = 1'b1;
         wt(4);
         v[i] = miso_o;
         sck_in = 1'b0;
      end
      done(1'b1, n);
      chk(v, d);
      ssn = 1'b1;
      wt(1);
      chk(miso_oe, 1'b0);
      rd(usrcfg_pkg::ADDR_DATA, v);
      chk(v, s);
      end_of_test;
   end
endmodule
